/* File: common/nvcs_map.svh */
/*
 * Register offsets, field positions, reset values, exit codes and geometry
 * constants of the command status unit.
 * Assumes it is included by bare name from rtl or package files.
 */
`ifndef NVCS_MAP_SVH
`define NVCS_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define NVCS_OFF_STATUS      12'h000
`define NVCS_OFF_CPU_PORT    12'h004
`define NVCS_OFF_DMA_PORT    12'h008
`define NVCS_OFF_CONTROL     12'h00c
`define NVCS_OFF_RESULT      12'h010
`define NVCS_OFF_GEOMETRY    12'h014

// ****************************************************************
// Status field positions and reset value
// ****************************************************************
`define NVCS_BIT_DATA_READY   0
`define NVCS_BIT_IDLE         1
`define NVCS_CODE_LSB         2
`define NVCS_CODE_MSB         7
`define NVCS_STATUS_RESET     8'h02

// ****************************************************************
// Control register fields (mode checks and reset value)
// ****************************************************************
`define NVCS_CTL_EXT_ACCESS   0
`define NVCS_CTL_PROG_MODE    1
`define NVCS_CTL_ASLEEP       2
`define NVCS_CTL_PROTECT      3
`define NVCS_CTL_VBE_EXT      4
`define NVCS_CTL_RESET        8'h03

// ****************************************************************
// Command keys
// ****************************************************************
`define NVCS_KEY1             8'hb6
`define NVCS_KEY2_BASE        8'hd3

// ****************************************************************
// Exit codes
// ****************************************************************
`define NVCS_EC_OK            6'h00
`define NVCS_EC_BAD_ARRAY     6'h01
`define NVCS_EC_BAD_KEY       6'h02
`define NVCS_EC_ASLEEP        6'h03
`define NVCS_EC_EXT_ACCESS    6'h04
`define NVCS_EC_BAD_COUNT     6'h05
`define NVCS_EC_TEST_MODE     6'h06
`define NVCS_EC_AW_ALG_SUM    6'h07
`define NVCS_EC_AW_PAR_SUM    6'h08
`define NVCS_EC_PROTECT       6'h09
`define NVCS_EC_BAD_ADDR      6'h0a
`define NVCS_EC_BAD_CMD       6'h0b
`define NVCS_EC_BAD_ROW       6'h0c
`define NVCS_EC_BAD_INPUT     6'h0d
`define NVCS_EC_VBE_EXT       6'h0e
`define NVCS_EC_BAD_STATE     6'h0f
`define NVCS_EC_AW_LO         6'h10
`define NVCS_EC_BASIC_VERIFY  6'h20

// ****************************************************************
// Memory geometry
// ****************************************************************
`define NVCS_ROW_CODE_BYTES   16'd256
`define NVCS_ROW_CFG_BYTES    16'd32
`define NVCS_ROW_BYTES        16'd288
`define NVCS_ARRAY_ROWS       16'd256
`define NVCS_PROT_BITS_ROW    2
`define NVCS_PROT_ROWS_BYTE   4
`define NVCS_EE_ROW_BYTES     16'd16
`define NVCS_RESP_DEPTH       8

`endif

/* File: common/nvcs_pkg.sv */
/*
 * Types of the command status unit.
 * Assumes nvcs_map.svh is on the include path.
 */
`include "nvcs_map.svh"

package nvcs_pkg;

	// Status register layout, bit 7 first.
	typedef struct packed {
		logic [5:0] exit_code;
		logic       controller_idle_flag;
		logic       data_ready;
	} nvcs_status_t;

	// Completion report from the execution engine.
	typedef struct packed {
		logic       done;
		logic       adaptive;
		logic       basic_alg;
		logic       verify_fail;
		logic [5:0] code;
	} nvcs_done_t;

	// Command byte handed to the execution engine.
	typedef struct packed {
		logic       valid;
		logic       from_dma;
		logic [7:0] data;
	} nvcs_cmd_byte_t;

	typedef enum logic [1:0] {
		NVCS_IDLE,
		NVCS_KEY2,
		NVCS_BUSY
	} nvcs_state_t;

endpackage

/* File: rtl/nvcs_status_unit.sv */
/*
 * Command status unit of the nonvolatile command controller: key check,
 * idle and data-ready flags, exit code, response return and an AXI4-Lite
 * register slave.
 * Assumes an execution engine outside that takes forwarded command bytes,
 * pushes response bytes and reports completion with an exit code.
 */
// The AXI4-Lite register port and the register addresses were left to the implementer.
// Operation
// - Bit 0 shows response data waiting.
// - Bit 1 is idle, low while busy.
// - First key 0xB6 drops idle at once.
// - Idle returns on completion or bad key.
// - Bits 7:2 hold last exit code.
// - Codes 0x00 to 0x03 defined meanings.
// - Codes 0x04 access, 0x06 programming mode.
// - Codes 0x05 count, 0x0A address, 0x0C row.
// - Codes 0x07, 0x08 adaptive write checksums.
// - Protection-blocked command refused with 0x09.
// - Codes 0x0D bad input, 0x0E sensor routed.
// - Codes 0x0B unknown command, 0x0F state.
// - Adaptive write returns codes 0x10 to 0x3F.
// - Basic row program verify failure gives 0x20.
// - Flash rows hold 288 bytes, whole-row programming.
// - Flash arrays of 128 or 256 rows.
// - Row protection governs debug and boot access.
// - Hidden row packs two bits per row.
// - EEPROM 32, 64 or 128 rows of 16.
// - Bytes written while busy are ignored; bytes on the command's own port are still forwarded.
// - Responses return through the command's port.
`include "nvcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module nvcs_status_unit (
	// Clock and reset.
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	// AXI4-Lite write address and data.
	input  wire logic                    s_axi_awvalid,
	output var  logic                    s_axi_awready,
	input  wire logic [11:0]             s_axi_awaddr,
	input  wire logic                    s_axi_wvalid,
	output var  logic                    s_axi_wready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	// AXI4-Lite write response.
	output var  logic                    s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	output var  logic [1:0]              s_axi_bresp,
	// AXI4-Lite read address and data.
	input  wire logic                    s_axi_arvalid,
	output var  logic                    s_axi_arready,
	input  wire logic [11:0]             s_axi_araddr,
	output var  logic                    s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	output var  logic [31:0]             s_axi_rdata,
	output var  logic [1:0]              s_axi_rresp,
	// Execution engine side.
	output var  nvcs_pkg::nvcs_cmd_byte_t cmd_byte,
	output var  logic [7:0]              cmd_code,
	input  wire nvcs_pkg::nvcs_done_t    engine_done,
	input  wire logic                    resp_push,
	input  wire logic [7:0]              resp_data,
	input  wire logic                    resp_last
);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Matches a word address against a register offset.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
		hit = (a[11:2] == off[11:2]);
	endfunction

	// Picks the code for a completion, honouring the algorithm in use.
	function automatic logic [5:0] done_code(input nvcs_pkg::nvcs_done_t d);
		if (d.basic_alg && d.verify_fail) begin
			done_code = `NVCS_EC_BASIC_VERIFY;
		end else if (d.adaptive) begin
			done_code = d.code;
		end else begin
			done_code = (d.code >= `NVCS_EC_AW_LO) ? `NVCS_EC_BAD_STATE : d.code;
		end
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	nvcs_pkg::nvcs_state_t state_q;
	logic                  idle_q;
	logic                  ready_q;
	logic [5:0]            code_q;
	logic                  port_dma_q;
	logic [7:0]            ctl_q;
	logic [7:0]            resp_q [`NVCS_RESP_DEPTH];
	logic [2:0]            wr_ptr_q;
	logic [2:0]            rd_ptr_q;
	logic [3:0]            cnt_q;
	logic                  last_seen_q;
	logic                  aw_hold_q;
	logic                  w_hold_q;
	logic [11:0]           aw_addr_q;
	logic [31:0]           w_data_q;
	logic [3:0]            w_strb_q;

	logic       wr_fire;
	logic       port_wr;
	logic       port_is_dma;
	logic       rd_fire;
	logic       pop;
	logic [7:0] wbyte;
	logic       refuse;
	logic [5:0] refuse_code;

	assign wr_fire     = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign port_is_dma = hit(aw_addr_q, `NVCS_OFF_DMA_PORT);
	assign port_wr     = wr_fire && w_strb_q[0] &&
	                     (hit(aw_addr_q, `NVCS_OFF_CPU_PORT) || port_is_dma);
	assign wbyte       = w_data_q[7:0];
	assign rd_fire     = s_axi_arvalid && s_axi_arready;
	// A read of the port that carried the command drains one response byte.
	assign pop         = rd_fire && (cnt_q != 4'h0) &&
	                     hit(s_axi_araddr, port_dma_q ? `NVCS_OFF_DMA_PORT :
	                         `NVCS_OFF_CPU_PORT);

	// Mode checks made on the command code byte before it is run.
	always_comb begin
		refuse      = 1'b1;
		refuse_code = `NVCS_EC_OK;
		if (!ctl_q[`NVCS_CTL_EXT_ACCESS]) begin
			refuse_code = `NVCS_EC_EXT_ACCESS;
		end else if (!ctl_q[`NVCS_CTL_PROG_MODE]) begin
			refuse_code = `NVCS_EC_TEST_MODE;
		end else if (ctl_q[`NVCS_CTL_ASLEEP]) begin
			refuse_code = `NVCS_EC_ASLEEP;
		end else if (ctl_q[`NVCS_CTL_PROTECT]) begin
			refuse_code = `NVCS_EC_PROTECT;
		end else if (ctl_q[`NVCS_CTL_VBE_EXT]) begin
			refuse_code = `NVCS_EC_VBE_EXT;
		end else begin
			refuse = 1'b0;
		end
	end

	// ****************************************************************
	// AXI4-Lite write path
	// ****************************************************************

	// Holds address and data separately so they may arrive in either order.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_hold_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Ready lines and the write response.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			// Ready stays low while a response waits, even if bready is held low.
			s_axi_awready <= !aw_hold_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				if (hit(aw_addr_q, `NVCS_OFF_CPU_PORT) || port_is_dma ||
				    hit(aw_addr_q, `NVCS_OFF_CONTROL)) begin
					s_axi_bresp <= 2'h0;
				end else begin
					s_axi_bresp <= 2'h2;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Control register that steers the mode checks.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctl_q <= `NVCS_CTL_RESET;
		end else if (wr_fire && w_strb_q[0] && hit(aw_addr_q, `NVCS_OFF_CONTROL)) begin
			ctl_q <= w_data_q[7:0];
		end
	end

	// ****************************************************************
	// Command sequencer and status flags
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q    <= nvcs_pkg::NVCS_IDLE;
			idle_q     <= 1'b1;
			code_q     <= `NVCS_EC_OK;
			port_dma_q <= 1'b0;
			cmd_byte   <= '0;
			cmd_code   <= 8'h00;
		end else begin
			cmd_byte <= '0;
			case (state_q)
				nvcs_pkg::NVCS_IDLE: begin
					if (port_wr && wbyte == `NVCS_KEY1) begin
						idle_q     <= 1'b0;
						port_dma_q <= port_is_dma;
						state_q    <= nvcs_pkg::NVCS_KEY2;
					end
				end
				nvcs_pkg::NVCS_KEY2: begin
					if (port_wr && port_is_dma == port_dma_q) begin
						cmd_code <= wbyte - `NVCS_KEY2_BASE;
						state_q  <= nvcs_pkg::NVCS_BUSY;
					end
				end
				nvcs_pkg::NVCS_BUSY: begin
					// The command code byte checks the key and the modes.
					if (port_wr && port_is_dma == port_dma_q && cmd_code != 8'hff) begin
						if (wbyte != cmd_code) begin
							code_q  <= `NVCS_EC_BAD_KEY;
							idle_q  <= 1'b1;
							state_q <= nvcs_pkg::NVCS_IDLE;
						end else if (refuse) begin
							code_q  <= refuse_code;
							idle_q  <= 1'b1;
							state_q <= nvcs_pkg::NVCS_IDLE;
						end else begin
							cmd_byte <= '{valid: 1'b1, from_dma: port_dma_q, data: wbyte};
							cmd_code <= 8'hff;
						end
					end else if (port_wr && port_is_dma == port_dma_q) begin
						cmd_byte <= '{valid: 1'b1, from_dma: port_dma_q, data: wbyte};
					end
					if (engine_done.done) begin
						code_q  <= done_code(engine_done);
						idle_q  <= 1'b1;
						state_q <= nvcs_pkg::NVCS_IDLE;
					end
				end
				default: begin
					state_q <= nvcs_pkg::NVCS_IDLE;
					idle_q  <= 1'b1;
				end
			endcase
			// Writes outside a command's own port while busy fall through.
		end
	end

	// ****************************************************************
	// Response bytes and data-ready flag
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr_q    <= 3'h0;
			rd_ptr_q    <= 3'h0;
			cnt_q       <= 4'h0;
			last_seen_q <= 1'b0;
			ready_q     <= 1'b0;
		end else begin
			if (resp_push && cnt_q != 4'h8) begin
				wr_ptr_q <= wr_ptr_q + 3'h1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 3'h1;
			end
			cnt_q <= cnt_q + {3'h0, resp_push && cnt_q != 4'h8} - {3'h0, pop};
			if (resp_push && resp_last) begin
				last_seen_q <= 1'b1;
			end else if (pop && cnt_q == 4'h1) begin
				last_seen_q <= 1'b0;
			end
			// Push wins over the emptying read so no byte goes unflagged.
			if (resp_push) begin
				ready_q <= 1'b1;
			end else if (pop && cnt_q == 4'h1) begin
				ready_q <= 1'b0;
			end
		end
	end

	// Response storage.
	always_ff @(posedge clk_sys) begin
		if (resp_push && cnt_q != 4'h8) begin
			resp_q[wr_ptr_q] <= resp_data;
		end
	end

	// ****************************************************************
	// AXI4-Lite read path
	// ****************************************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				if (hit(s_axi_araddr, `NVCS_OFF_STATUS)) begin
					s_axi_rdata <= {24'h0, code_q, idle_q, ready_q};
				end else if (hit(s_axi_araddr, `NVCS_OFF_CPU_PORT) ||
				             hit(s_axi_araddr, `NVCS_OFF_DMA_PORT)) begin
					s_axi_rdata <= {24'h0, pop ? resp_q[rd_ptr_q] : 8'h00};
				end else if (hit(s_axi_araddr, `NVCS_OFF_CONTROL)) begin
					s_axi_rdata <= {24'h0, ctl_q};
				end else if (hit(s_axi_araddr, `NVCS_OFF_RESULT)) begin
					s_axi_rdata <= {23'h0, last_seen_q, 4'h0, cnt_q};
				end else if (hit(s_axi_araddr, `NVCS_OFF_GEOMETRY)) begin
					// Row size and rows per array for software.
					s_axi_rdata <= {`NVCS_ARRAY_ROWS, `NVCS_ROW_BYTES};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Geometry of protection and EEPROM is fixed by the engine.

endmodule

`default_nettype wire

/* File: tb/nvcs_engine_model.sv */
/* Behavioural execution engine facing the status unit.
   Assumes the bench sets the controls before each command. */
`timescale 1ns/1ps
`default_nettype none
// ********
// Engine model
// ********
module nvcs_engine_model (
	// Clock and reset.
	input wire logic                     clk_sys,
	input wire logic                     rst,
	// Forwarded bytes.
	input wire nvcs_pkg::nvcs_cmd_byte_t cmd_byte,
	// Scenario controls.
	input wire logic [5:0]               e_code,
	input wire logic                     e_adapt,
	input wire logic                     e_basic,
	input wire logic                     e_vfail,
	input wire logic [3:0]               e_need,
	input wire logic [3:0]               e_nresp,
	input wire logic [7:0]               e_delay,
	// Completion and responses.
	output var nvcs_pkg::nvcs_done_t     engine_done,
	output var logic                     resp_push,
	output var logic [7:0]               resp_data,
	output var logic                     resp_last
);
	int got;
	int t;
	int sent;
	// Counts bytes, waits, pushes responses, then reports completion.
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			got = 0;
			t = -1;
			sent = 0;
			engine_done <= '0;
			resp_push <= 1'b0;
			resp_last <= 1'b0;
			resp_data <= 8'h00;
		end else begin
			engine_done <= '0;
			resp_push <= 1'b0;
			if (cmd_byte.valid === 1'b1) got++;
			if (t < 0) begin
				if (got >= e_need) t = e_delay;
			end else if (t > 0) begin
				t--;
			end else if (sent < e_nresp) begin
				resp_push <= 1'b1;
				resp_data <= 8'ha0 + 8'(sent);
				resp_last <= (sent == e_nresp - 1);
				sent++;
			end else begin
				engine_done <= {1'b1, e_adapt, e_basic, e_vfail, e_code};
				got = 0;
				t = -1;
				sent = 0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/nvcs_status_sva.sv */
/* Port checker of the command status unit.
   Assumes it is bound onto nvcs_status_unit and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module nvcs_status_sva (
	// Clock and reset.
	input wire logic                     clk_sys,
	input wire logic                     rst,
	// Bus handshakes.
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	// Forwarded command bytes.
	input wire nvcs_pkg::nvcs_cmd_byte_t cmd_byte
);
	logic [2:0] since_w_q;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Counts cycles since the last write data beat, saturating at seven.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			since_w_q <= 3'h7;
		end else if (s_axi_wvalid && s_axi_wready) begin
			since_w_q <= 3'h0;
		end else if (since_w_q != 3'h7) begin
			since_w_q <= since_w_q + 3'h1;
		end
	end
	// Address and data of one write taken at the same edge.
	sequence w_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// The write response two cycles later.
	sequence b_answer;
		##2 s_axi_bvalid;
	endsequence
	wr_latency_a: assert property (w_take |-> b_answer)
		else $error("write response late");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data repeated");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while a response is pending");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data is pending");
	fwd_pulse_a: assert property (cmd_byte.valid |=> !cmd_byte.valid)
		else $error("forwarded byte longer than one cycle");
	fwd_cause_a: assert property (cmd_byte.valid |-> since_w_q <= 3'h3)
		else $error("forwarded byte without a port write");
endmodule

bind nvcs_status_unit nvcs_status_sva nvcs_status_sva_inst (
	.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .cmd_byte
);
`default_nettype wire

/* File: tb/tb_top.sv */
/* Self-checking bench of the command status unit.
   Assumes nvcs_pkg, the engine model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench top
// ********
module tb_top;
	// Design, engine and bench signals.
	logic                     clk_sys, rst, resp_push, resp_last, e_adapt, e_basic, e_vfail;
	logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                     s_axi_rvalid, s_axi_rready;
	logic [11:0]              s_axi_awaddr, s_axi_araddr;
	logic [31:0]              s_axi_wdata, s_axi_rdata, rd, seed;
	logic [3:0]               s_axi_wstrb, e_need, e_nresp;
	logic [1:0]               s_axi_bresp, s_axi_rresp, rs;
	logic [7:0]               cmd_code, resp_data, e_delay;
	logic [5:0]               e_code;
	nvcs_pkg::nvcs_cmd_byte_t cmd_byte;
	nvcs_pkg::nvcs_done_t     engine_done;
	int                       n_mismatch = 0, n_checks = 0, n_fwd = 0, exp_code = 0, f0 = 0;
	logic [7:0]               resp_q[$];
	logic [5:0]               codes[10] = '{6'h00, 6'h01, 6'h05, 6'h0a, 6'h0c,
	                                        6'h0d, 6'h0b, 6'h07, 6'h08, 6'h0f};
	logic [7:0]               ctl[6] = '{8'h03, 8'h02, 8'h01, 8'h07, 8'h0b, 8'h13};
	logic [5:0]               ecs[6] = '{6'h02, 6'h04, 6'h06, 6'h03, 6'h09, 6'h0e};

	nvcs_status_unit nvcs_status_unit_inst (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.cmd_byte, .cmd_code, .engine_done, .resp_push, .resp_data, .resp_last);
	nvcs_engine_model nvcs_engine_model_inst (.clk_sys, .rst, .cmd_byte, .e_code, .e_adapt,
		.e_basic, .e_vfail, .e_need, .e_nresp, .e_delay, .engine_done, .resp_push,
		.resp_data, .resp_last);

	// Free-running system clock.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Counts bytes handed to the engine.
	always @(posedge clk_sys) begin
		if (cmd_byte.valid === 1'b1) n_fwd++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected status from the reference model, controller idle.
	function automatic logic [31:0] stat();
		return {24'h0, exp_code[5:0], 1'b1, resp_q.size() != 0};
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// One bus write of a byte; the response code lands in rs.
	task automatic axi_wr(input logic [11:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_sys);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (k == 40) n_mismatch++;
	endtask
	// One bus read; data lands in rd and the response code in rs.
	task automatic axi_rd(input logic [11:0] a);
		int k;
		@(posedge clk_sys);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		s_axi_araddr <= a;
		for (k = 0; k < 40; k++) begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (k == 40) n_mismatch++;
	endtask
	// Sends both keys, the code and np parameter bytes; off spoils the second key.
	task automatic send(input logic [11:0] p, input logic [7:0] c, input logic [7:0] off,
		input int np);
		int i;
		axi_wr(p, 8'hb6);
		axi_rd(12'h000);
		check("idle_low", rd & 32'h2, 32'h0);
		axi_wr(p, 8'hd3 + c + off);
		axi_wr(p, c);
		for (i = 0; i < np; i++) begin
			axi_wr(p, seed[7:0]);
			seed = lfsr(seed);
		end
	endtask
	task automatic wait_idle();
		int k;
		for (k = 0; k < 60; k++) begin
			axi_rd(12'h000);
			if (rd[1] === 1'b1) break;
		end
		check("status", rd, stat());
	endtask
	// Reads every response back through port p, then the status once more.
	task automatic drain(input logic [11:0] p);
		while (resp_q.size() > 0) begin
			axi_rd(p);
			check("resp", rd, {24'h0, resp_q.pop_front()});
		end
		axi_rd(12'h000);
		check("status_held", rd, stat());
	endtask
	// One accepted command; x makes it slow and writes the first key to the CPU port meanwhile.
	task automatic eng(input logic [5:0] c, input logic [2:0] f, input logic [3:0] n,
		input logic [11:0] p, input int ex, input bit x);
		int i;
		f0 = n_fwd;
		e_code <= c;
		{e_adapt, e_basic, e_vfail} <= f;
		e_nresp <= n;
		e_delay <= x ? 8'd60 : {4'h0, seed[3:0]};
		for (i = 0; i < n; i++) resp_q.push_back(8'ha0 + 8'(i));
		exp_code = ex;
		send(p, seed[15:8], 8'h00, 1);
		check("port_bresp", {30'h0, rs}, 32'h0);
		check("cmd_code", {24'h0, cmd_code}, 32'hff);
		if (x) axi_wr(12'h004, 8'hb6);
		wait_idle();
		check("fwd", n_fwd - f0, 32'h2);
		drain(p);
	endtask

	// Main sequence: reset, register access, commands, refusals.
	initial begin
		int i;
		seed = 32'hca56;
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{e_code, e_adapt, e_basic, e_vfail, e_nresp, e_delay} = '0;
		e_need = 4'h2;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		axi_rd(12'h000);
		check("reset_status", rd, stat());
		axi_rd(12'h100);
		check("unmapped", {30'h0, rs}, 32'h2);
		axi_wr(12'h000, 8'hff);
		check("ro_write", {30'h0, rs}, 32'h2);
		for (i = 0; i < 10; i++) begin
			eng(codes[i], 3'h0, 4'(i % 3), 12'h004, codes[i], 1'b0);
		end
		eng(6'h15, 3'h0, 4'h1, 12'h004, 6'h0f, 1'b0);
		eng(6'(16 + seed % 48), 3'h4, 4'h2, 12'h004, 16 + seed % 48, 1'b0);
		eng(6'h00, 3'h3, 4'h0, 12'h004, 6'h20, 1'b0);
		eng(6'h00, 3'h0, 4'h2, 12'h008, 6'h00, 1'b1);
		for (i = 0; i < 6; i++) begin
			axi_wr(12'h00c, ctl[i]);
			f0 = n_fwd;
			exp_code = ecs[i];
			send(12'h004, 8'h21, 8'(i == 0), 0);
			wait_idle();
			check("refused_fwd", n_fwd - f0, 32'h0);
		end
		wrap_up();
	end
	// Watchdog against a hung handshake.
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end
endmodule
`default_nettype wire
